// *** rtl/pulse_gen_pkg.sv ***
// Shared constants and carriers for the two-channel pulse train and PWM generator
package pulse_gen_pkg;
  // Control byte field positions
  localparam int CTL_UPD_CYCLE = 0;
  localparam int CTL_UPD_WIDTH = 1;
  localparam int CTL_UPD_COUNT = 2;
  localparam int CTL_TIMEBASE_MS = 3;
  localparam int CTL_SYNC_UPDATE = 4;
  localparam int CTL_MULTI_SEG = 5;
  localparam int CTL_PWM_MODE = 6;
  localparam int CTL_ENABLE = 7;
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CYCLE_RESET = 16'h0000;
  localparam logic [15:0] WIDTH_RESET = 16'h0000;
  localparam logic [31:0] COUNT_RESET = 32'h00000000;
  // Cycle time floor, in time-base units
  localparam logic [15:0] MIN_CYCLE = 16'h0002;
  // Profile table layout
  localparam int SEG_ENTRY_BYTES = 8;
  localparam int SEG_HDR_BYTES = 1;
  // Time base
  localparam int CLK_HZ = 50_000_000;
  localparam int US_TICK_NS = 1000;
  localparam int US_TICK_CYCLES = (US_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int MS_PER_US = 1000;

  // Programming parameters of one channel
  typedef struct packed {
    logic [7:0] ctl;
    logic [31:0] count;
    logic [15:0] cycle;
    logic [15:0] width;
    logic [15:0] offset;
  } chan_cfg_s;

  // Status of one channel
  typedef struct packed {
    logic idle;
    logic overflow;
    logic user_abort;
    logic delta_error;
    logic seg_count_error;
    logic [7:0] segment;
  } chan_stat_s;
endpackage

// *** rtl/pulse_train_and_pwm_generator.sv ***
// Two-channel pulse train / PWM generator driving the fast outputs
// How it works
// - Two generators, each on its own output
// - Control byte, 32b count, 16b cycle/width
// - Active generator alone drives its pin
// - Inactive pin follows the image bit
// - All parameters and control zero after reset
// - Square wave for exactly programmed pulse count
// - Zero pulse count means one pulse
// - Cycle counted in microsecond or millisecond ticks
// - Cycle below two units becomes two
// - Odd cycle gives one tick duty skew
// - Queued train starts with no gap
// - Command while busy fills one-entry queue
// - Seamless unless time base changes or underrun
// - Multi-segment fetches entries from data memory
// - One time base for whole profile
// - Table: count byte then 8-byte entries
// - Add signed delta to cycle per pulse
// - Publish current segment number
// - Zero segment count errors, no output
// - PWM continuous; full width high, zero low
// - Synchronous update applies at cycle boundary
// - Asynchronous update restarts generator immediately
// - Update bit picks method; time base forces async
// - Illegal delta result stops train, flags error
// - Overflow flag sticky until cleared or run entry
// - Abort flag on profile disable; idle on completion
`timescale 1ns/1ps
`default_nettype none
module pulse_train_and_pwm_generator #(
  parameter int CHANNELS = 2,
  parameter int MEM_AW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pulse_gen_pkg::chan_cfg_s cfg [2],
  input wire logic [1:0] pulse_output_command,
  input wire logic [1:0] image_bit,
  input wire logic [1:0] overflow_clear,
  input wire logic run_entry,
  output logic [1:0] mem_req,
  output logic [MEM_AW-1:0] mem_addr [2],
  input wire logic [1:0] mem_ack,
  input wire logic [7:0] mem_rdata [2],
  output var pulse_gen_pkg::chan_stat_s status [2],
  output logic first_fast_output,
  output logic second_fast_output
);
  logic [1:0] pin;

  // One generator per output
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g = g + 1) begin : gen_ch
      typedef enum logic [2:0] {IDLE, RUN, F_HDR, F_SEG, HOLD} state_e;
      state_e state;
      state_e next_state;
      logic [7:0] ctl;
      logic [7:0] next_ctl;
      logic [16:0] cycle;
      logic [16:0] next_cycle;
      logic [15:0] width;
      logic [15:0] next_width;
      logic [31:0] left;
      logic [31:0] next_left;
      logic [15:0] phase;
      logic [15:0] next_phase;
      logic [15:0] delta;
      logic [15:0] next_delta;
      logic q_full;
      logic next_q_full;
      logic [15:0] q_cycle;
      logic [15:0] next_q_cycle;
      logic [31:0] q_count;
      logic [31:0] next_q_count;
      logic q_ms;
      logic next_q_ms;
      logic [7:0] seg_total;
      logic [7:0] next_seg_total;
      logic [7:0] seg;
      logic [7:0] next_seg;
      logic [2:0] byte_idx;
      logic [2:0] next_byte_idx;
      logic [MEM_AW-1:0] addr;
      logic [MEM_AW-1:0] next_addr;
      logic req;
      logic next_req;
      logic drive;
      logic next_drive;
      logic out_q;
      logic next_out_q;
      logic idle_f;
      logic next_idle_f;
      logic ovf_f;
      logic next_ovf_f;
      logic abort_f;
      logic next_abort_f;
      logic derr_f;
      logic next_derr_f;
      logic serr_f;
      logic next_serr_f;
      logic tick;
      logic [16:0] ramped;
      logic [15:0] cmd_cycle;
      logic [31:0] cmd_count;
      logic cmd;
      logic busy;
      logic cyc_end;
      // Per-channel prescaler, so a start from a non-running state never begins with a cut tick
      logic [15:0] us_cnt;
      logic [15:0] next_us_cnt;
      logic [9:0] ms_cnt;
      logic [9:0] next_ms_cnt;
      logic us_tick;
      logic ms_tick;

      // Cycle floor and count substitution on the requested values
      function automatic logic [15:0] floor_cycle(input logic [15:0] c);
        floor_cycle = (c < pulse_gen_pkg::MIN_CYCLE) ? pulse_gen_pkg::MIN_CYCLE : c;
      endfunction

      always_comb begin
        us_tick = (us_cnt == 16'(pulse_gen_pkg::US_TICK_CYCLES - 1));
        ms_tick = us_tick && (ms_cnt == 10'(pulse_gen_pkg::MS_PER_US - 1));
        cmd = pulse_output_command[g];
        busy = (state != IDLE);
        tick = ctl[pulse_gen_pkg::CTL_TIMEBASE_MS] ? ms_tick : us_tick;
        cyc_end = tick && (phase == cycle[15:0] - 16'h0001);
        cmd_cycle = cfg[g].ctl[pulse_gen_pkg::CTL_UPD_CYCLE] ? floor_cycle(cfg[g].cycle)
                                                             : floor_cycle(cycle[15:0]);
        cmd_count = cfg[g].ctl[pulse_gen_pkg::CTL_UPD_COUNT] ? cfg[g].count : left;
        if (cmd_count == 32'h00000000) begin
          cmd_count = 32'h00000001;
        end
        ramped = cycle + {delta[15], delta};
        next_state = state;
        next_ctl = ctl;
        next_cycle = cycle;
        next_width = width;
        next_left = left;
        next_phase = phase;
        next_delta = delta;
        next_q_full = q_full;
        next_q_cycle = q_cycle;
        next_q_count = q_count;
        next_q_ms = q_ms;
        next_seg_total = seg_total;
        next_seg = seg;
        next_byte_idx = byte_idx;
        next_addr = addr;
        next_req = 1'b0;
        next_drive = busy && state != HOLD;
        next_idle_f = idle_f;
        next_ovf_f = ovf_f;
        next_abort_f = abort_f;
        next_derr_f = derr_f;
        next_serr_f = serr_f;
        if (overflow_clear[g] || run_entry) begin
          next_ovf_f = 1'b0;
        end
        if (tick && state == RUN) begin
          next_phase = phase + 16'h0001;
        end
        // Running waveform
        if (state == RUN && cyc_end) begin
          next_phase = 16'h0000;
          if (!ctl[pulse_gen_pkg::CTL_PWM_MODE]) begin
            if (left > 32'h00000001) begin
              next_left = left - 32'h00000001;
              if (ctl[pulse_gen_pkg::CTL_MULTI_SEG]) begin
                if (ramped < 17'(pulse_gen_pkg::MIN_CYCLE) || ramped[16]) begin
                  next_derr_f = 1'b1;
                  next_state = IDLE;
                  next_idle_f = 1'b1;
                end else begin
                  next_cycle = ramped;
                end
              end
            end else if (ctl[pulse_gen_pkg::CTL_MULTI_SEG]) begin
              if (seg == seg_total) begin
                next_state = IDLE;
                next_idle_f = 1'b1;
              end else begin
                next_state = F_SEG;
                next_byte_idx = 3'h0;
                next_req = 1'b1;
              end
            end else if (q_full) begin
              next_cycle = {1'b0, q_cycle};
              next_left = q_count;
              next_q_full = 1'b0;
              next_ctl[pulse_gen_pkg::CTL_TIMEBASE_MS] = q_ms;
            end else begin
              next_state = IDLE;
              next_idle_f = 1'b1;
            end
          end
        end
        // Profile table fetch, big-endian: high byte of each field first
        if ((state == F_HDR || state == F_SEG) && mem_ack[g]) begin
          next_addr = addr + MEM_AW'(1);
          if (state == F_HDR) begin
            next_seg_total = mem_rdata[g];
            if (mem_rdata[g] == 8'h00) begin
              next_serr_f = 1'b1;
              next_state = IDLE;
              next_idle_f = 1'b1;
            end else begin
              next_state = F_SEG;
              next_byte_idx = 3'h0;
              next_req = 1'b1;
            end
          end else begin
            next_req = (byte_idx != 3'h7);
            next_byte_idx = byte_idx + 3'h1;
            case (byte_idx)
              3'h0: next_cycle = {1'b0, mem_rdata[g], cycle[7:0]};
              3'h1: next_cycle = {1'b0, cycle[15:8], mem_rdata[g]};
              3'h2: next_delta = {mem_rdata[g], delta[7:0]};
              3'h3: next_delta = {delta[15:8], mem_rdata[g]};
              3'h4: next_left = {mem_rdata[g], left[23:0]};
              3'h5: next_left = {left[31:24], mem_rdata[g], left[15:0]};
              3'h6: next_left = {left[31:16], mem_rdata[g], left[7:0]};
              default: begin
                next_left = {left[31:8], mem_rdata[g]};
                if ({left[31:8], mem_rdata[g]} == 32'h00000000) begin
                  next_left = 32'h00000001;
                end
                next_cycle = {1'b0, floor_cycle(cycle[15:0])};
                next_seg = seg + 8'h01;
                next_phase = 16'h0000;
                next_state = RUN;
              end
            endcase
          end
        end else if (state == F_HDR || state == F_SEG) begin
          next_req = req && !mem_ack[g];
        end
        if (state == HOLD) begin
          next_state = RUN;
          next_phase = 16'h0000;
        end
        // Program command from software
        if (cmd) begin
          if (!cfg[g].ctl[pulse_gen_pkg::CTL_ENABLE]) begin
            if (busy && ctl[pulse_gen_pkg::CTL_MULTI_SEG] && !ctl[pulse_gen_pkg::CTL_PWM_MODE]) begin
              next_abort_f = 1'b1;
            end
            next_state = IDLE;
            next_idle_f = 1'b1;
            next_q_full = 1'b0;
            next_ctl = cfg[g].ctl;
          end else if (cfg[g].ctl[pulse_gen_pkg::CTL_PWM_MODE]) begin
            next_ctl = cfg[g].ctl;
            next_cycle = {1'b0, cmd_cycle};
            next_width = cfg[g].ctl[pulse_gen_pkg::CTL_UPD_WIDTH] ? cfg[g].width : width;
            if (busy && ctl[pulse_gen_pkg::CTL_PWM_MODE] && cfg[g].ctl[pulse_gen_pkg::CTL_SYNC_UPDATE]
                && cfg[g].ctl[pulse_gen_pkg::CTL_TIMEBASE_MS] == ctl[pulse_gen_pkg::CTL_TIMEBASE_MS]) begin
              next_q_full = 1'b1;
              next_q_cycle = cmd_cycle;
              next_q_count = {16'h0000, next_width}; // Take the new width before restoring
              next_ctl = ctl;
              next_cycle = cycle;
              next_width = width;
            end else begin
              next_state = HOLD;
            end
            next_idle_f = 1'b0;
          end else if (cfg[g].ctl[pulse_gen_pkg::CTL_MULTI_SEG]) begin
            next_ctl = cfg[g].ctl;
            next_addr = cfg[g].offset[MEM_AW-1:0];
            next_seg = 8'h00;
            next_state = F_HDR;
            next_req = 1'b1;
            next_idle_f = 1'b0;
          end else if (busy && state == RUN && !ctl[pulse_gen_pkg::CTL_PWM_MODE]) begin
            if (q_full && !(cyc_end && left == 32'h00000001)) begin
              next_ovf_f = 1'b1;
            end else begin
              next_q_full = 1'b1;
              next_q_cycle = cmd_cycle;
              next_q_count = cmd_count;
              next_q_ms = cfg[g].ctl[pulse_gen_pkg::CTL_TIMEBASE_MS];
            end
          end else begin
            next_ctl = cfg[g].ctl;
            next_cycle = {1'b0, cmd_cycle};
            next_left = cmd_count;
            next_phase = 16'h0000;
            next_state = RUN;
            next_idle_f = 1'b0;
          end
        end
        // PWM sync update lands at the cycle boundary
        if (!cmd && state == RUN && ctl[pulse_gen_pkg::CTL_PWM_MODE] && cyc_end && q_full) begin
          next_cycle = {1'b0, q_cycle};
          next_width = q_count[15:0];
          next_q_full = 1'b0;
        end
        // Waveform level; image bit when not driving
        if (next_drive && state == RUN) begin
          if (ctl[pulse_gen_pkg::CTL_PWM_MODE]) begin
            next_out_q = (width >= cycle[15:0]) || (phase < width);
          end else begin
            next_out_q = (phase < {1'b0, cycle[15:1]});
          end
        end else if (next_drive) begin
          next_out_q = out_q;
        end else begin
          next_out_q = image_bit[g];
        end
        // Restart only on a fresh start; queued trains keep the tick phase to stay gapless
        if (next_state == RUN && state != RUN) begin
          next_us_cnt = 16'h0000;
          next_ms_cnt = 10'h000;
        end else begin
          next_us_cnt = us_tick ? 16'h0000 : us_cnt + 16'h0001;
          next_ms_cnt = ms_tick ? 10'h000 : (us_tick ? ms_cnt + 10'h001 : ms_cnt);
        end
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          state <= IDLE;
          ctl <= pulse_gen_pkg::CTL_RESET;
          cycle <= {1'b0, pulse_gen_pkg::CYCLE_RESET};
          width <= pulse_gen_pkg::WIDTH_RESET;
          left <= pulse_gen_pkg::COUNT_RESET;
          phase <= 16'h0000;
          delta <= 16'h0000;
          q_full <= 1'b0;
          q_cycle <= 16'h0000;
          q_count <= 32'h00000000;
          q_ms <= 1'b0;
          seg_total <= 8'h00;
          seg <= 8'h00;
          byte_idx <= 3'h0;
          addr <= '0;
          req <= 1'b0;
          drive <= 1'b0;
          out_q <= 1'b0;
          idle_f <= 1'b1;
          ovf_f <= 1'b0;
          abort_f <= 1'b0;
          derr_f <= 1'b0;
          serr_f <= 1'b0;
          us_cnt <= 16'h0000;
          ms_cnt <= 10'h000;
        end else begin
          state <= next_state;
          ctl <= next_ctl;
          cycle <= next_cycle;
          width <= next_width;
          left <= next_left;
          phase <= next_phase;
          delta <= next_delta;
          q_full <= next_q_full;
          q_cycle <= next_q_cycle;
          q_count <= next_q_count;
          q_ms <= next_q_ms;
          seg_total <= next_seg_total;
          seg <= next_seg;
          byte_idx <= next_byte_idx;
          addr <= next_addr;
          req <= next_req;
          drive <= next_drive;
          out_q <= next_out_q;
          idle_f <= next_idle_f;
          ovf_f <= next_ovf_f;
          abort_f <= next_abort_f;
          derr_f <= next_derr_f;
          serr_f <= next_serr_f;
          us_cnt <= next_us_cnt;
          ms_cnt <= next_ms_cnt;
        end
      end

      assign pin[g] = out_q;
      assign mem_req[g] = req;
      assign mem_addr[g] = addr;
      assign status[g] = '{idle: idle_f, overflow: ovf_f, user_abort: abort_f,
                           delta_error: derr_f, seg_count_error: serr_f, segment: seg};
    end
  endgenerate

  assign first_fast_output = pin[0];
  assign second_fast_output = pin[1];
endmodule
`default_nettype wire

// *** tb/drive_mem_model.sv ***
// Data memory holding profile tables, answering one byte fetch at a time
`timescale 1ns/1ps
`default_nettype none
module drive_mem_model #(
  parameter int MEM_AW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] mem_req,
  input wire logic [MEM_AW-1:0] mem_addr [2],
  output logic [1:0] mem_ack,
  output logic [7:0] mem_rdata [2]
);
  logic [7:0] mem [64];
  int wait_cnt [2];
  // Channel 0 answers at once, channel 1 slowly
  localparam int LAT [2] = '{0, 3};
  task automatic put(input int base, input logic [71:0] v);
    for (int k = 0; k < 9; k++) begin
      mem[base + k] = v[71 - 8 * k -: 8];
    end
  endtask
  // Count byte, then cycle, delta and count with high byte first
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    put(16, 72'h01_0002_0002_00000002);
    put(32, 72'h01_0002_ffff_00000003);
    put(48, 72'h01_0010_0000_00000009);
  end
  // Data line flips after each answer so a stale byte is never mistaken for fresh
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 2'h0;
      mem_rdata <= '{8'h00, 8'h00};
      wait_cnt <= '{0, 0};
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (mem_ack[g]) begin
          mem_ack[g] <= 1'b0;
          mem_rdata[g] <= ~mem_rdata[g];
          wait_cnt[g] <= 0;
        end else if (mem_req[g] && wait_cnt[g] >= LAT[g]) begin
          mem_ack[g] <= 1'b1;
          mem_rdata[g] <= mem[mem_addr[g][5:0]];
        end else if (mem_req[g]) begin
          wait_cnt[g] <= wait_cnt[g] + 1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/pulse_gen_properties.sv ***
// Port-level concurrent checks for the two-channel pulse generator
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_properties #(
  parameter int MEM_AW = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pulse_gen_pkg::chan_cfg_s cfg [2],
  input wire logic [1:0] pulse_output_command,
  input wire logic [1:0] image_bit,
  input wire logic [1:0] overflow_clear,
  input wire logic run_entry,
  input wire logic [1:0] mem_req,
  input wire logic [MEM_AW-1:0] mem_addr [2],
  input wire logic [1:0] mem_ack,
  input wire pulse_gen_pkg::chan_stat_s status [2],
  input wire logic first_fast_output,
  input wire logic second_fast_output
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Length of the current high run; each high run of the first pin must last a whole number of ticks
  logic [31:0] hi_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hi_cnt <= 32'h0;
    end else begin
      hi_cnt <= first_fast_output ? hi_cnt + 32'h1 : 32'h0;
    end
  end
  // Three idle cycles are required since idle and pin may settle one cycle apart
  idle_follow_a: assert property (status[0].idle && $past(status[0].idle)
    && $past(status[0].idle, 2) && $stable(image_bit[0]) |-> first_fast_output == image_bit[0])
    else $error("first pin not following image bit while idle");
  second_idle_follow_a: assert property (status[1].idle && $past(status[1].idle)
    && $past(status[1].idle, 2) && $stable(image_bit[1]) |-> second_fast_output == image_bit[1])
    else $error("second pin not following image bit while idle");
  start_high_a: assert property (pulse_output_command[0] && cfg[0].ctl[7]
    && !cfg[0].ctl[6] && !cfg[0].ctl[5] && status[0].idle && !image_bit[0]
    |-> ##1 !first_fast_output ##1 first_fast_output)
    else $error("pulse train did not start high two cycles after command");
  busy_after_cmd_a: assert property (pulse_output_command[0] && cfg[0].ctl[7] && !cfg[0].ctl[5]
    |=> !status[0].idle)
    else $error("idle still set after program command");
  tick_width_a: assert property ($fell(first_fast_output) && !status[0].idle
    |-> (hi_cnt % pulse_gen_pkg::US_TICK_CYCLES) == 0)
    else $error("high time not a whole number of ticks");
  ovf_sticky_a: assert property (status[0].overflow && !overflow_clear[0] && !run_entry
    |=> status[0].overflow)
    else $error("overflow flag dropped without a clear");
  ovf_clear_a: assert property (overflow_clear[0] && !pulse_output_command[0]
    |=> !status[0].overflow)
    else $error("overflow flag not cleared");
  run_clear_a: assert property (run_entry && pulse_output_command == 2'h0
    |=> !status[0].overflow && !status[1].overflow)
    else $error("run entry left an overflow flag set");
  delta_sticky_a: assert property (status[1].delta_error |=> status[1].delta_error)
    else $error("delta error flag dropped");
  seg_err_idle_a: assert property ($rose(status[0].seg_count_error) |-> status[0].idle)
    else $error("empty profile left generator busy");
  mem_hold_a: assert property (mem_req[0] && !mem_ack[0]
    |=> mem_req[0] && $stable(mem_addr[0]))
    else $error("table fetch request dropped or moved before ack");
  cover property (status[0].segment == 8'h01);
  cover property ($rose(status[0].overflow));
  cover property ($rose(status[1].delta_error));
endmodule
bind pulse_train_and_pwm_generator pulse_gen_properties #(.MEM_AW(MEM_AW)) props (
  .clk, .reset_n, .cfg, .pulse_output_command, .image_bit, .overflow_clear, .run_entry,
  .mem_req, .mem_addr, .mem_ack, .status, .first_fast_output, .second_fast_output);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the two-channel pulse generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pulse_gen_pkg::chan_cfg_s cfg [2];
  logic [1:0] pulse_output_command = 2'h0;
  logic [1:0] image_bit = 2'h0;
  logic [1:0] overflow_clear = 2'h0;
  logic run_entry = 1'b0;
  logic [1:0] mem_req;
  logic [15:0] mem_addr [2];
  logic [1:0] mem_ack;
  logic [7:0] mem_rdata [2];
  pulse_gen_pkg::chan_stat_s status [2];
  logic first_fast_output;
  logic second_fast_output;
  logic [1:0] pin;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int hi [2];
  int rises [2];
  int t;
  assign pin = {second_fast_output, first_fast_output};
  pulse_train_and_pwm_generator #(.CHANNELS(2), .MEM_AW(16)) dut (
    .clk, .reset_n, .cfg, .pulse_output_command, .image_bit, .overflow_clear, .run_entry,
    .mem_req, .mem_addr, .mem_ack, .mem_rdata, .status, .first_fast_output,
    .second_fast_output);
  drive_mem_model #(.MEM_AW(16)) memory (.clk, .reset_n, .mem_req, .mem_addr, .mem_ack,
    .mem_rdata);
  // 50 MHz clock
  always #10 clk = ~clk;
  // Hang guard: about twice the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      err_total++;
      final_report();
    end
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input int g, input logic [7:0] c, input logic [31:0] n,
      input logic [15:0] cy, input logic [15:0] w, input logic [15:0] o);
    @(negedge clk);
    cfg[g] = {c, n, cy, w, o};
    pulse_output_command[g] = 1'b1;
    @(negedge clk);
    pulse_output_command[g] = 1'b0;
  endtask
  // Counts high cycles and rising edges of both pins over n clocks
  task automatic meas(input int n);
    logic [1:0] last;
    hi = '{0, 0};
    rises = '{0, 0};
    last = pin;
    repeat (n) begin
      @(negedge clk);
      for (int g = 0; g < 2; g++) begin
        hi[g] += pin[g];
        rises[g] += pin[g] & ~last[g];
      end
      last = pin;
    end
  endtask
  task automatic reset_check();
    chk("status0", status[0], 32'h1000);
    chk("status1", status[1], 32'h1000);
    chk("pins", pin, 32'h0);
    image_bit = 2'h3;
    repeat (3) @(negedge clk);
    chk("pins image", pin, 32'h3);
    image_bit = 2'h0;
    repeat (3) @(negedge clk);
  endtask
  // Both channels at once: odd cycle on one, zero count and cycle on the other
  task automatic pto_pair();
    @(negedge clk);
    cfg[0] = {8'h85, 32'h2, 16'h3, 16'h0, 16'h0};
    cfg[1] = {8'h85, 32'h0, 16'h0, 16'h0, 16'h0};
    pulse_output_command = 2'h3;
    @(negedge clk);
    pulse_output_command = 2'h0;
    meas(320);
    chk("rises0", rises[0], 32'h2);
    chk("high0", hi[0], 32'h64);
    chk("rises1", rises[1], 32'h1);
    chk("high1", hi[1], 32'h32);
    chk("idle0", status[0].idle, 32'h1);
    chk("idle1", status[1].idle, 32'h1);
  endtask
  // Queue one train behind a running one, then overrun the queue
  task automatic pipeline();
    cmd(0, 8'h85, 32'h1, 16'h2, 16'h0, 16'h0);
    cmd(0, 8'h85, 32'h1, 16'h2, 16'h0, 16'h0);
    cmd(0, 8'h85, 32'h1, 16'h2, 16'h0, 16'h0);
    meas(150);
    chk("queued rises", rises[0], 32'h1);
    chk("queued high", hi[0], 32'h60);
    chk("overflow", status[0].overflow, 32'h1);
    run_entry = 1'b1;
    @(negedge clk);
    run_entry = 1'b0;
    @(negedge clk);
    chk("overflow run", status[0].overflow, 32'h0);
    overflow_clear = 2'h3;
    @(negedge clk);
    overflow_clear = 2'h0;
    repeat (60) @(negedge clk);
  endtask
  task automatic pwm_run();
    cmd(0, 8'hc3, 32'h0, 16'h4, 16'h1, 16'h0);
    meas(800);
    chk("pwm rises", rises[0], 32'h4);
    chk("pwm high", hi[0], 32'hc8);
    cmd(0, 8'hd2, 32'h0, 16'h0, 16'h2, 16'h0);
    repeat (200) @(negedge clk);
    meas(800);
    chk("sync high", hi[0], 32'h190);
    chk("sync rises", rises[0], 32'h4);
    cmd(0, 8'hd2, 32'h0, 16'h0, 16'h9, 16'h0);
    repeat (300) @(negedge clk);
    meas(400);
    chk("full high", hi[0], 32'h190);
    cmd(0, 8'hd2, 32'h0, 16'h0, 16'h0, 16'h0);
    repeat (300) @(negedge clk);
    image_bit = 2'h1;
    meas(400);
    chk("zero high", hi[0], 32'h0);
    cmd(0, 8'h00, 32'h0, 16'h0, 16'h0, 16'h0);
    repeat (5) @(negedge clk);
    chk("off pin", pin[0], 32'h1);
    image_bit = 2'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic profiles();
    cmd(0, 8'ha0, 32'h0, 16'h0, 16'h0, 16'h0);
    meas(300);
    chk("empty rises", rises[0], 32'h0);
    chk("empty flag", status[0].seg_count_error, 32'h1);
    cmd(0, 8'ha0, 32'h0, 16'h0, 16'h0, 16'h10);
    meas(150);
    t = hi[0];
    chk("segment", status[0].segment, 32'h1);
    meas(500);
    chk("ramp high", t + hi[0], 32'h96);
    chk("ramp idle", status[0].idle, 32'h1);
    cmd(1, 8'ha0, 32'h0, 16'h0, 16'h0, 16'h20);
    meas(600);
    chk("fault rises", rises[1], 32'h1);
    chk("fault flag", status[1].delta_error, 32'h1);
    chk("fault pin", pin[1], 32'h0);
    cmd(0, 8'ha0, 32'h0, 16'h0, 16'h0, 16'h30);
    meas(400);
    chk("long rises", rises[0], 32'h1);
    image_bit = 2'h1;
    cmd(0, 8'h20, 32'h0, 16'h0, 16'h0, 16'h0);
    repeat (5) @(negedge clk);
    chk("abort flag", status[0].user_abort, 32'h1);
    chk("abort pin", pin[0], 32'h1);
  endtask
  initial begin
    cfg[0] = 88'h0;
    cfg[1] = 88'h0;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    reset_check();
    pto_pair();
    pipeline();
    pwm_run();
    profiles();
    final_report();
  end
endmodule
`default_nettype wire
